// *** rtl/spi_continuous_address_looper.v ***
// Serial slave with auto-stepping register address pointer.
// Assumes clk runs well above the serial clock (at least 8x), register
// read data arrives combinationally from rd_addr, and the loop fields
// come from the communication status/configuration register outside.
`timescale 1ns/100ps
`include "looper_regs.vh"
module spi_continuous_address_looper (
   input  wire                  clk,
   input  wire                  rst,
   input  wire                  cs_n,
   input  wire                  sck,
   input  wire                  sdi,
   output wire                  sdo,
   output wire                  sdo_oe,
   input  wire [1:0]            read_loop,
   input  wire                  write_loop,
   input  wire [1:0]            width_sel,
   output wire [`ADDR_W-1:0]    rd_addr,
   input  wire [`DATA_W-1:0]    rd_data,
   output wire                  rd_load,
   output wire                  wr_valid,
   input  wire                  wr_ready,
   output wire [`ADDR_W-1:0]    wr_addr,
   output wire [`DATA_W-1:0]    wr_data,
   output wire                  busy
);
   // ---------------------------------------------------------------
   // States
   // ---------------------------------------------------------------
   localparam ST_CTRL   = 2'h0;
   localparam ST_READ   = 2'h1;
   localparam ST_WRITE  = 2'h2;
   localparam ST_IGNORE = 2'h3;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   wire cs_n_s;
   wire sck_s;
   wire sdi_s;

   pin_sync #(.RESET_VAL(1'b1)) u_sync_cs (
      .clk   (clk),
      .rst   (rst),
      .pin   (cs_n),
      .level (cs_n_s)
   );
   pin_sync #(.RESET_VAL(1'b0)) u_sync_sck (
      .clk   (clk),
      .rst   (rst),
      .pin   (sck),
      .level (sck_s)
   );
   pin_sync #(.RESET_VAL(1'b0)) u_sync_sdi (
      .clk   (clk),
      .rst   (rst),
      .pin   (sdi),
      .level (sdi_s)
   );

   reg  [1:0]         state_reg;
   reg  [1:0]         state_next;
   reg  [5:0]         bit_cnt_reg;
   reg  [`DATA_W-1:0] shift_in_reg;
   reg  [`DATA_W-1:0] shift_out_reg;
   reg  [`ADDR_W-1:0] ptr_reg;
   reg                load_pend_reg;
   reg                sck_prev_reg;
   wire               sck_rise;
   wire               sck_fall;

   assign sck_rise = sck_s && !sck_prev_reg;
   assign sck_fall = !sck_s && sck_prev_reg;

   // ---------------------------------------------------------------
   // Word length
   // ---------------------------------------------------------------
   reg [5:0] word_bits;

   always @* begin
      case (width_sel)
         `WIDTH_16: word_bits = `BITS_16;
         `WIDTH_24: word_bits = `BITS_24;
         default:   word_bits = `BITS_32;
      endcase
   end

   wire [5:0] last_bit;
   wire       bit_done;
   wire       ctrl_done;
   wire       word_done;

   assign last_bit  = (state_reg == ST_CTRL) ? `CTRL_BITS : word_bits;
   assign bit_done  = sck_rise && (bit_cnt_reg + 6'h01 == last_bit);
   assign ctrl_done = bit_done && (state_reg == ST_CTRL);
   assign word_done = bit_done && (state_reg != ST_CTRL);

   // ---------------------------------------------------------------
   // Set membership per address
   // ---------------------------------------------------------------
   wire       is_read;
   wire [31:0] defined_mask;
   wire [31:0] member;

   assign is_read      = (state_reg == ST_READ);
   assign defined_mask = `DEFINED_MASK;

   genvar gi;
   generate
      for (gi = 0; gi < 32; gi = gi + 1) begin : g_member
         wire [`ADDR_W-1:0] a;
         wire               same_group;
         wire               same_type;
         reg                in_set;
         assign a          = gi[`ADDR_W-1:0];
         assign same_group = (a[`ADDR_W-1:`GROUP_LSB] == ptr_reg[`ADDR_W-1:`GROUP_LSB]);
         assign same_type  = ((a >= `WRITE_FIRST) == (ptr_reg >= `WRITE_FIRST));
         always @* begin
            if (is_read) begin
               case (read_loop)
                  `RLOOP_GROUPS: in_set = same_group;
                  `RLOOP_TYPES:  in_set = same_type;
                  `RLOOP_FULL:   in_set = 1'b1;
                  default:       in_set = (a == ptr_reg);
               endcase
            end else begin
               case (write_loop)
                  `WLOOP_TYPES: in_set = (a >= `WRITE_FIRST);
                  default:      in_set = (a == ptr_reg);
               endcase
            end
         end
         // Undefined addresses never join a set
         assign member[gi] = in_set && defined_mask[gi];
      end
   endgenerate

   // ---------------------------------------------------------------
   // Next address: first member above pointer, else first member
   // ---------------------------------------------------------------
   reg [`ADDR_W-1:0] next_addr;
   reg [`ADDR_W-1:0] first_addr;
   reg               found_above;
   reg               found_first;
   integer           i;

   always @* begin
      next_addr   = ptr_reg;
      first_addr  = ptr_reg;
      found_above = 1'b0;
      found_first = 1'b0;
      for (i = 0; i < 32; i = i + 1) begin
         if (member[i] && !found_first) begin
            first_addr  = i[`ADDR_W-1:0];
            found_first = 1'b1;
         end
         if (member[i] && !found_above && (i > ptr_reg)) begin
            next_addr   = i[`ADDR_W-1:0];
            found_above = 1'b1;
         end
      end
      if (!found_above) begin
         next_addr = first_addr;
      end
   end

   // ---------------------------------------------------------------
   // Write acceptance
   // ---------------------------------------------------------------
   wire               writable;
   wire               fifo_in_ready;
   wire               push;
   wire [`DATA_W-1:0] word_in;

   assign writable = defined_mask[ptr_reg] && (ptr_reg >= `WRITE_FIRST)
                     && (ptr_reg <= `WRITE_LAST);
   assign word_in  = {shift_in_reg[`DATA_W-2:0], sdi_s};
   // A full buffer refuses the word just like a locked address would
   assign push     = word_done && (state_reg == ST_WRITE) && writable;

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_CTRL: begin
            if (ctrl_done) begin
               if (word_in[`CTRL_DEV_MSB:`CTRL_DEV_LSB] != `DEV_ADDR) begin
                  // Frame belongs to another device sharing the select line
                  state_next = ST_IGNORE;
               end else if (word_in[`CTRL_RW_BIT]) begin
                  state_next = ST_READ;
               end else begin
                  state_next = ST_WRITE;
               end
            end
         end
         // Loops end only through select release, handled in the register
         ST_READ: begin
            state_next = ST_READ;
         end
         ST_WRITE: begin
            state_next = ST_WRITE;
         end
         ST_IGNORE: begin
            state_next = ST_IGNORE;
         end
         default: begin
            state_next = ST_CTRL;
         end
      endcase
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg     <= ST_CTRL;
         bit_cnt_reg   <= 6'h00;
         shift_in_reg  <= {`DATA_W{1'b0}};
         shift_out_reg <= {`DATA_W{1'b0}};
         ptr_reg       <= {`ADDR_W{1'b0}};
         load_pend_reg <= 1'b0;
         sck_prev_reg  <= 1'b0;
      end else begin
         sck_prev_reg <= sck_s;
         if (cs_n_s) begin
            // Select high ends the loop and clears the interface
            state_reg     <= ST_CTRL;
            bit_cnt_reg   <= 6'h00;
            load_pend_reg <= 1'b0;
         end else begin
            state_reg <= state_next;
            if (sck_rise) begin
               if (bit_done) begin
                  bit_cnt_reg <= 6'h00;
               end else begin
                  bit_cnt_reg <= bit_cnt_reg + 6'h01;
               end
               // Input ignored in read loops
               if (state_reg != ST_READ) begin
                  shift_in_reg <= word_in;
               end
            end
            if (ctrl_done) begin
               ptr_reg       <= word_in[`CTRL_ADDR_MSB:`CTRL_ADDR_LSB];
               load_pend_reg <= (state_next == ST_READ);
            end else if (word_done && state_reg == ST_READ) begin
               ptr_reg       <= next_addr;
               load_pend_reg <= 1'b1;
            end else if (push && fifo_in_ready) begin
               ptr_reg       <= next_addr;
            end else begin
               load_pend_reg <= 1'b0;
            end
            if (load_pend_reg) begin
               shift_out_reg <= rd_data;
            end else if (sck_fall && bit_cnt_reg != 6'h00 && state_reg == ST_READ) begin
               shift_out_reg <= {shift_out_reg[`DATA_W-2:0], 1'b0};
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Buffered write words
   // ---------------------------------------------------------------
   wire [`ADDR_W+`DATA_W-1:0] fifo_out;

   word_fifo #(
      .WIDTH (`ADDR_W + `DATA_W),
      .DEPTH (`FIFO_DEPTH),
      .AW    (`FIFO_AW)
   ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   ({ptr_reg, word_in}),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  (fifo_out)
   );

   assign wr_addr = fifo_out[`ADDR_W+`DATA_W-1:`DATA_W];
   assign wr_data = fifo_out[`DATA_W-1:0];

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // MSB placement follows the selected width so short words also shift out MSB first
   reg sdo_bit;

   always @* begin
      case (width_sel)
         `WIDTH_16: sdo_bit = shift_out_reg[15];
         `WIDTH_24: sdo_bit = shift_out_reg[23];
         default:   sdo_bit = shift_out_reg[31];
      endcase
   end

   assign sdo     = sdo_bit;
   assign sdo_oe  = (state_reg == ST_READ) && !cs_n_s;
   assign rd_addr = ptr_reg;
   assign rd_load = load_pend_reg;
   assign busy    = !cs_n_s;

endmodule // spi_continuous_address_looper

// *** rtl/looper_regs.vh ***
// Constants of the serial address-pointer looper.
// Assumes the includer wraps logic around these definitions only.
// Function
// - One control byte after select falls; then registers follow without commands.
// - Keep looping over registers while select is low; stop only when it rises.
// - First register moved is the address carried in the control byte.
// - After each full register, step pointer to next address of selected set; a write word refused by a full buffer keeps the pointer.
// - After the set's last address, wrap to its first and continue.
// - Skip undefined addresses while stepping; they are outside the map.
// - Set is picked by two-bit read-loop and one-bit write-loop fields.
// - Read-loop field offers four different address groupings.
// - Read-loop 00 static, 01 groups, 10 types (default), 11 full map.
// - Write-loop 0 static, 1 types (default).
// - During continuous reads, serial input after the control byte is ignored.
// - Writes to non-writable addresses do nothing and keep the pointer.
`ifndef LOOPER_REGS_VH
`define LOOPER_REGS_VH

// ---------------------------------------------------------------
// Control byte
// ---------------------------------------------------------------
`define CTRL_BITS      6'h08
`define CTRL_RW_BIT    0
`define CTRL_ADDR_LSB  1
`define CTRL_ADDR_MSB  5
`define CTRL_DEV_LSB   6
`define CTRL_DEV_MSB   7
`define DEV_ADDR       2'h1

// ---------------------------------------------------------------
// Word widths
// ---------------------------------------------------------------
`define WIDTH_16       2'h0
`define WIDTH_24       2'h1
`define BITS_16        6'h10
`define BITS_24        6'h18
`define BITS_32        6'h20
`define DATA_W         32
`define ADDR_W         5

// ---------------------------------------------------------------
// Loop encodings
// ---------------------------------------------------------------
`define RLOOP_STATIC   2'h0
`define RLOOP_GROUPS   2'h1
`define RLOOP_TYPES    2'h2
`define RLOOP_FULL     2'h3
`define WLOOP_STATIC   1'h0
`define WLOOP_TYPES    1'h1
`define RLOOP_RESET    2'h2
`define WLOOP_RESET    1'h1

// ---------------------------------------------------------------
// Register map shape
// ---------------------------------------------------------------
`define DEFINED_MASK   32'h800f_ff03
`define WRITE_FIRST    5'h08
`define WRITE_LAST     5'h1f
`define GROUP_LSB      2

// ---------------------------------------------------------------
// Buffering
// ---------------------------------------------------------------
`define FIFO_DEPTH     16
`define FIFO_AW        4

`endif

// *** rtl/pin_sync.v ***
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to clk; output changes once
// the second and third stages agree.
`timescale 1ns/100ps
module pin_sync #(
   parameter RESET_VAL = 1'b0
) (
   input  wire clk,
   input  wire rst,
   input  wire pin,
   output reg  level
);
   reg s1_reg;
   reg s2_reg;
   reg s3_reg;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_reg <= RESET_VAL;
         s2_reg <= RESET_VAL;
         s3_reg <= RESET_VAL;
         level  <= RESET_VAL;
      end else begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         // Only a settled value passes; a single odd sample is held off
         if (s2_reg == s3_reg) begin
            level <= s3_reg;
         end
      end
   end
endmodule // pin_sync

// *** rtl/word_fifo.v ***
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock domain; DEPTH is a power of two of 2**AW.
`timescale 1ns/100ps
module word_fifo #(
   parameter WIDTH = 37,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clk,
   input  wire             rst,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_reg;
   reg [AW-1:0]    rd_ptr_reg;
   reg [AW:0]      count_reg;
   wire            push;
   wire            pop;

   assign in_ready  = (count_reg != DEPTH[AW:0]);
   assign out_valid = (count_reg != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ptr_reg];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule // word_fifo

// *** tb/spi_host_model.sv ***
// Host model: mode 0,0 serial master, eight clk periods per bit.
// Assumes clk at 10 MHz; the caller runs one frame at a time.
`timescale 1ns/100ps
module spi_host_model (
   input  wire  clk,
   output logic cs_n,
   output logic sck,
   output logic sdi,
   input  wire  sdo
);
   initial begin
      cs_n = 1'b1;
      sck  = 1'b0;
      sdi  = 1'b0;
   end
   // ------------------------------------------------------------
   // Frame tasks
   // ------------------------------------------------------------
   // Bits change just after an edge; sdo is taken just before the
   // next fall, since the device moves it only after it sees a fall
   task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
      rx = 32'h0;
      for (int i = n - 1; i >= 0; i--) begin
         sck <= 1'b0;
         sdi <= tx[i];
         repeat (4) @(posedge clk);
         sck <= 1'b1;
         repeat (4) @(posedge clk);
         rx[i] = sdo;
      end
   endtask
   task automatic open_frame(input logic [7:0] ctrl);
      logic [31:0] rx;
      @(posedge clk);
      cs_n <= 1'b0;
      repeat (6) @(posedge clk);
      xfer({24'h0, ctrl}, 8, rx);
   endtask
   // Idle sdi flips so a stale level is never mistaken for data
   task automatic close_frame;
      sck <= 1'b0;
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      sdi  <= ~sdi;
      repeat (8) @(posedge clk);
   endtask
endmodule // spi_host_model

// *** tb/looper_asserts.sv ***
// Port assertions for the address looper, bound into every instance.
// Assumes the four-clock synchroniser latency and one-clock load delay.
`timescale 1ns/100ps
`include "looper_regs.vh"
module looper_checker (
   input wire               clk,
   input wire               rst,
   input wire               cs_n,
   input wire               sdo_oe,
   input wire [1:0]         read_loop,
   input wire [`ADDR_W-1:0] rd_addr,
   input wire               rd_load,
   input wire               wr_valid,
   input wire [`ADDR_W-1:0] wr_addr,
   input wire               busy
);
   localparam logic [31:0] DEF = `DEFINED_MASK;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // ------------------------------------------------------------
   // Sequences and properties
   // ------------------------------------------------------------
   sequence s_sel_seen;
      ##[1:6] busy;
   endsequence
   sequence s_rel_seen;
      ##[1:6] (!busy && !sdo_oe);
   endsequence
   sequence s_step;
      sdo_oe && $past(sdo_oe) && $changed(rd_addr);
   endsequence
   property p_sel;
      $fell(cs_n) |-> s_sel_seen;
   endproperty
   property p_hold;
      busy && !cs_n |=> busy;
   endproperty
   property p_rel;
      $rose(cs_n) |-> s_rel_seen;
   endproperty
   property p_quiet;
      cs_n [*6] |-> !sdo_oe && !busy;
   endproperty
   property p_gap;
      rd_load |=> !rd_load [*8];
   endproperty
   property p_def;
      s_step |-> DEF[rd_addr];
   endproperty
   property p_load;
      s_step |-> ##[0:2] rd_load;
   endproperty
   property p_static;
      read_loop == `RLOOP_STATIC && sdo_oe && $past(sdo_oe) |-> $stable(rd_addr);
   endproperty
   property p_types;
      read_loop == `RLOOP_TYPES and s_step
         |-> (rd_addr >= `WRITE_FIRST) == ($past(rd_addr) >= `WRITE_FIRST);
   endproperty
   property p_groups;
      read_loop == `RLOOP_GROUPS and s_step |-> (rd_addr >> 2) == ($past(rd_addr) >> 2);
   endproperty
   property p_wr;
      wr_valid |-> DEF[wr_addr] && wr_addr >= `WRITE_FIRST;
   endproperty
   a_sel: assert property (p_sel)
      else $error("select not seen in time");
   a_hold: assert property (p_hold)
      else $error("loop left while select low");
   a_rel: assert property (p_rel)
      else $error("loop not ended after select rise");
   a_quiet: assert property (p_quiet)
      else $error("activity while deselected");
   a_gap: assert property (p_gap)
      else $error("word loads too close");
   a_def: assert property (p_def)
      else $error("pointer on undefined address");
   a_load: assert property (p_load)
      else $error("no load after pointer step");
   a_static: assert property (p_static)
      else $error("static read pointer moved");
   a_types: assert property (p_types)
      else $error("types read left its type");
   a_groups: assert property (p_groups)
      else $error("groups read left its group");
   a_wr: assert property (p_wr)
      else $error("word written to non-writable address");
endmodule // looper_checker
bind spi_continuous_address_looper looper_checker chk (.clk, .rst, .cs_n, .sdo_oe,
   .read_loop, .rd_addr, .rd_load, .wr_valid, .wr_addr, .busy);

// *** tb/testbench.sv ***
// Bench: host model drives the looper; bench plays register file and sink.
// Assumes rtl on the include path and the checker bound from its file.
`timescale 1ns/100ps
`include "looper_regs.vh"
module testbench;
   localparam logic [31:0] DEF = `DEFINED_MASK;
   logic                clk        = 1'b0;
   logic                rst        = 1'b1;
   logic [1:0]          read_loop  = `RLOOP_RESET;
   logic                write_loop = `WLOOP_RESET;
   logic [1:0]          width_sel  = `WIDTH_24;
   logic                wr_ready   = 1'b1;
   wire                 cs_n, sck, sdi, sdo, sdo_line, sdo_oe, rd_load, wr_valid, busy;
   wire [`ADDR_W-1:0]   rd_addr, wr_addr;
   wire [`DATA_W-1:0]   rd_data, wr_data;
   int                  err_total  = 0;
   int                  compares   = 0;
   logic [36:0]         got_q[$];
   always #50 clk = ~clk;
   // Register file stand-in: contents tell the address apart
   assign rd_data = {8'h3c, 8'ha5, 3'h0, rd_addr, 8'hc3};
   // Released data line shows the inverse, so a missing enable spoils the read
   assign sdo_line = sdo_oe ? sdo : ~sdo;
   always @(posedge clk)
      if (wr_valid && wr_ready)
         got_q.push_back({wr_addr, wr_data});
   spi_continuous_address_looper DUT (.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck),
      .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .read_loop(read_loop),
      .write_loop(write_loop), .width_sel(width_sel), .rd_addr(rd_addr),
      .rd_data(rd_data), .rd_load(rd_load), .wr_valid(wr_valid), .wr_ready(wr_ready),
      .wr_addr(wr_addr), .wr_data(wr_data), .busy(busy));
   spi_host_model host (.clk(clk), .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo(sdo_line));
   // ------------------------------------------------------------
   // Reference model and helpers
   // ------------------------------------------------------------
   function automatic logic member(logic [4:0] c, logic [4:0] a, logic [1:0] m);
      return DEF[c] && (m == 2'h3 || (m == 2'h2 && (c >= 5'h08) == (a >= 5'h08))
         || (m == 2'h1 && c[4:2] == a[4:2]) || c == a);
   endfunction
   function automatic logic [4:0] step(logic [4:0] a, logic [1:0] m);
      logic [4:0] c;
      for (int k = 1; k < 32; k++) begin
         c = a + 5'(k);
         if (member(c, a, m))
            return c;
      end
      return a;
   endfunction
   task automatic check(input logic [36:0] got, input logic [36:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("compares %0d, mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Read frame with sdi held high through the data words, which must be ignored
   task automatic read_seq(input logic [4:0] a, input logic [1:0] m, input logic [1:0] ws,
                           input int n);
      logic [31:0] rx;
      logic [31:0] mask;
      logic [31:0] e;
      int          bits;
      bits = (ws == `WIDTH_16) ? 16 : (ws == `WIDTH_24) ? 24 : 32;
      mask = 32'hffff_ffff >> (32 - bits);
      @(posedge clk);
      read_loop <= m;
      width_sel <= ws;
      host.open_frame({`DEV_ADDR, a, 1'b1});
      for (int w = 0; w < n; w++) begin
         host.xfer(32'hffff_ffff, bits, rx);
         e = {8'h3c, 8'ha5, 3'h0, a, 8'hc3} & mask;
         check({5'h0, rx & mask}, {5'h0, e}, "read word");
         a = step(a, m);
      end
      host.close_frame();
      check({36'h0, wr_valid}, 37'h0, "read wrote nothing");
   endtask
   // Write frame; tail bits form a partial word, keep is words expected
   task automatic write_seq(input logic [4:0] a, input logic wl, input logic [1:0] ws,
                            input int n, input int tail, input int keep);
      logic [31:0] rx;
      logic [31:0] mask;
      logic [36:0] e;
      int          bits;
      bits = (ws == `WIDTH_16) ? 16 : 24;
      mask = (ws == `WIDTH_16) ? 32'h0000_ffff : 32'h00ff_ffff;
      @(posedge clk);
      write_loop <= wl;
      width_sel  <= ws;
      got_q.delete();
      host.open_frame({`DEV_ADDR, a, 1'b0});
      for (int w = 0; w < n; w++)
         host.xfer(32'h005a_0000 + 32'(w), bits, rx);
      if (tail > 0)
         host.xfer(32'h0, tail, rx);
      host.close_frame();
      wr_ready <= 1'b1;
      repeat (24) @(posedge clk);
      check(37'(got_q.size()), 37'(keep), "words written");
      for (int w = 0; w < keep; w++) begin
         e = got_q.pop_front();
         check({e[36:32], e[31:0] & mask}, {a, (32'h005a_0000 + 32'(w)) & mask},
               "written word");
         a = step(a, wl ? 2'h2 : 2'h0);
      end
   endtask
   task automatic t_read_modes;
      read_seq(5'h09, `RLOOP_STATIC, `WIDTH_24, 2);
      read_seq(5'h01, `RLOOP_GROUPS, `WIDTH_16, 3);
      read_seq(5'h12, `RLOOP_TYPES, `WIDTH_24, 4);
      read_seq(5'h1f, `RLOOP_FULL, 2'h2, 4);
      $display("read loop modes done");
   endtask
   task automatic t_writes;
      write_seq(5'h13, `WLOOP_TYPES, `WIDTH_24, 3, 0, 3);
      write_seq(5'h0a, `WLOOP_STATIC, `WIDTH_16, 2, 9, 2);
      write_seq(5'h02, `WLOOP_TYPES, `WIDTH_24, 2, 0, 0);
      write_seq(5'h08, `WLOOP_TYPES, `WIDTH_24, 1, 0, 1);
      $display("write loop modes done");
   endtask
   // Another device's address: the whole frame must pass unseen
   task automatic t_foreign;
      logic [31:0] rx;
      @(posedge clk);
      got_q.delete();
      host.open_frame({~`DEV_ADDR, 5'h08, 1'b0});
      host.xfer(32'h0012_3456, 24, rx);
      host.xfer(32'h0065_4321, 24, rx);
      host.close_frame();
      repeat (4) @(posedge clk);
      check(37'(got_q.size()), 37'h0, "foreign frame wrote");
      $display("foreign device frame done");
   endtask
   // Sink stalls through the frame; words past the depth are lost
   task automatic t_fifo_full;
      @(posedge clk);
      wr_ready <= 1'b0;
      write_seq(5'h0b, `WLOOP_STATIC, `WIDTH_16, `FIFO_DEPTH + 2, 0, `FIFO_DEPTH);
      check({36'h0, wr_valid}, 37'h0, "fifo drained");
      $display("fifo fill and drain done");
   endtask
   initial begin
      #3_000_000;
      err_total++;
      $display("ERROR %0t: watchdog expired", $time);
      finish_test();
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      t_read_modes();
      t_writes();
      t_foreign();
      t_fifo_full();
      finish_test();
   end
endmodule // testbench
